/* logic/acf_cfg.svh */
// Purpose: offsets, field positions and reset values of the compare/filter
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   included by the package, the compare/filter module and the testbench
`ifndef ACF_CFG_SVH
`define ACF_CFG_SVH

`define ACF_OFF_CMP_CTL  12'h000
`define ACF_OFF_LOW_THR  12'h004
`define ACF_OFF_MASK_LO  12'h008
`define ACF_OFF_MASK_HI  12'h00c
`define ACF_OFF_FLT_CTL  12'h010
`define ACF_OFF_FLT_DAT  12'h014
`define ACF_OFF_IRQ_STS  12'h018
`define ACF_OFF_IRQ_MSK  12'h01c
`define ACF_OFF_CMP_CHN  12'h020
`define ACF_BUF_PAGE     5'h01

`define ACF_BIT_BLL      0
`define ACF_MASK_HI_W    2
`define ACF_BIT_FLT_EN   15
`define ACF_LSB_FLT_MODE 13
`define ACF_LSB_FLT_RAT  10
`define ACF_BIT_FLT_IE   9
`define ACF_BIT_FLT_RDY  8
`define ACF_LSB_FLT_CHN  0
`define ACF_BIT_IRQ_CMP  0
`define ACF_BIT_IRQ_FLT  1

`define ACF_RST_CTL      16'h0000
`define ACF_RST_THR      16'h0000
`define ACF_RST_MASK     18'h00000
`define ACF_RST_IRQ      2'h0
`define ACF_CH_TEMP      5'h10
`define ACF_CH_BGAP      5'h11

`endif

/* logic/acf_pkg.sv */
// Purpose: shared types and the register decoder
// Assumes: acf_cfg.svh on the include path
// Notes:   no state lives here
`include "acf_cfg.svh"

package acf_pkg;

  typedef logic [4:0]  acf_chan_t;
  typedef logic [15:0] acf_sample_t;

  typedef enum logic [3:0] {
    ACF_R_NONE    = 4'h0,
    ACF_R_CMP_CTL = 4'h1,
    ACF_R_LOW_THR = 4'h2,
    ACF_R_MASK_LO = 4'h3,
    ACF_R_MASK_HI = 4'h4,
    ACF_R_FLT_CTL = 4'h5,
    ACF_R_FLT_DAT = 4'h6,
    ACF_R_IRQ_STS = 4'h7,
    ACF_R_IRQ_MSK = 4'h8,
    ACF_R_CMP_CHN = 4'h9,
    ACF_R_BUF     = 4'ha
  } acf_reg_t;

  function automatic acf_reg_t acf_decode(input logic [11:0] addr,
                                          input logic [5:0]  nch);
    acf_reg_t r;
    r = ACF_R_NONE;
    if (addr[1:0] == 2'h0) begin
      case (addr)
        `ACF_OFF_CMP_CTL: r = ACF_R_CMP_CTL;
        `ACF_OFF_LOW_THR: r = ACF_R_LOW_THR;
        `ACF_OFF_MASK_LO: r = ACF_R_MASK_LO;
        `ACF_OFF_MASK_HI: r = ACF_R_MASK_HI;
        `ACF_OFF_FLT_CTL: r = ACF_R_FLT_CTL;
        `ACF_OFF_FLT_DAT: r = ACF_R_FLT_DAT;
        `ACF_OFF_IRQ_STS: r = ACF_R_IRQ_STS;
        `ACF_OFF_IRQ_MSK: r = ACF_R_IRQ_MSK;
        `ACF_OFF_CMP_CHN: r = ACF_R_CMP_CHN;
        default: begin
          if (addr[11:7] == `ACF_BUF_PAGE && {1'b0, addr[6:2]} < nch) begin
            r = ACF_R_BUF;
          end
        end
      endcase
    end
    return r;
  endfunction

endpackage

/* logic/acf_mem_if.sv */
// Purpose: carries the result-buffer ports between controller and memory
// Assumes: one write port, one registered read port
// Notes:   read data appear one edge after rd_en
`timescale 1ns/10ps

interface acf_mem_if #(
  parameter int AW = 5,
  parameter int DW = 16
);
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic          rd_en;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;

  modport ctl (output wr_en, output wr_addr, output wr_data,
               output rd_en, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data,
               input rd_en, input rd_addr, output rd_data);
endinterface

/* logic/acf_result_mem.sv */
// Purpose: per-channel result buffers, one word per channel
// Assumes: addresses below DEPTH only
// Notes:   contents are not reset; read data come from a register
`timescale 1ns/10ps

module acf_result_mem #(
  parameter int DEPTH = 18
) (
  // clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_resetn,
  // controller side
  acf_mem_if.mem    port
);

  logic [15:0] store [DEPTH];
  logic [15:0] rd_data_reg;

  always_ff @(posedge i_clk_sys) begin
    if (port.wr_en && 32'(port.wr_addr) < DEPTH) begin
      store[port.wr_addr] <= port.wr_data;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      rd_data_reg <= 16'h0000;
    end else if (port.rd_en && 32'(port.rd_addr) < DEPTH) begin
      rd_data_reg <= store[port.rd_addr];
    end
  end

  assign port.rd_data = rd_data_reg;

endmodule

/* logic/acf_adc_cmp_filter.sv */
// Purpose: digital low-threshold comparator, channel masks and
//          oversampling filter control of the adc post-processing
// Assumes: conversion results arrive as one-cycle valid strobes,
//          synchronous to i_clk_sys; APB slave with one wait state
// Notes:   filter ratio here means 2^(ratio+1) accumulated samples
// Notes on behaviour
// (R1) below-low enable set: event when buffered result is under low threshold
// (R2) low mask register holds sixteen channel enables, channels 0 to 15
// (R3) cleared enable bit keeps that channel from ever raising an event
// (R4) high mask register holds channels 16 and 17 in bits 0 and 1
// (R5) high mask bits 15 to 2 read zero, writes to them ignored
// (R6) all channel enables read/write, reset to zero
// (R7) filter control layout: en, mode, ratio, ie, ready, channel select
// (R8) filter channel codes 0-15 analog, 16 temp, 17 bandgap, rest reserved
// (R9) each enabled result checked once on write, event two cycles later
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/10ps

`include "acf_cfg.svh"

module acf_adc_cmp_filter
  import acf_pkg::*;
#(
  parameter int NUM_CH = 18
) (
  // clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_resetn,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // conversion results
  input  wire logic        i_res_valid,
  input  wire acf_chan_t   i_res_chan,
  input  wire acf_sample_t i_res_data,
  // events
  output logic             o_cmp_event,
  output acf_chan_t        o_cmp_chan,
  output logic             o_flt_ready,
  output logic             o_irq
);

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  acf_mem_if #(.AW(5), .DW(16)) mem_bus ();

  // register state
  logic              below_low_event_enable_reg;
  acf_sample_t       low_threshold_reg;
  logic [NUM_CH-1:0] channel_compare_enable_reg;
  logic              filter_enable_reg;
  logic [1:0]        filter_mode_reg;
  logic [2:0]        filter_ratio_reg;
  logic              filter_interrupt_enable_reg;
  logic              flt_rdy_reg;
  acf_chan_t         filter_input_channel_reg;
  logic [31:0]       flt_data_reg;
  logic [24:0]       flt_sum_reg;
  logic [8:0]        flt_cnt_reg;
  logic [1:0]        irq_sts_reg;
  logic [1:0]        irq_msk_reg;
  logic              irq_reg;
  acf_chan_t         cmp_chan_reg;
  logic              cmp_event_reg;

  // apb handshake state
  logic              pready_reg;
  logic              pslverr_reg;
  logic [31:0]       prdata_reg;
  logic [31:0]       prdata_next;

  // result pipeline
  logic              res_vld_reg;
  acf_chan_t         res_chan_reg;
  acf_sample_t       res_data_reg;

  logic              apb_setup;
  logic              apb_first;
  logic              apb_done;
  logic              apb_wr;
  logic              apb_rd;
  acf_reg_t          sel;
  logic              chan_en;
  logic              cmp_hit;
  logic              flt_take;
  logic              flt_done;
  logic [8:0]        flt_cnt_inc;
  logic [8:0]        flt_target;
  logic [24:0]       flt_sum_inc;
  logic [15:0]       flt_ctl_view;

  assign apb_setup = i_psel && !i_penable;
  assign apb_first = i_psel && i_penable && !pready_reg;
  assign apb_done  = i_psel && i_penable && pready_reg;
  assign apb_wr    = apb_done && i_pwrite;
  assign apb_rd    = apb_done && !i_pwrite;
  assign sel       = acf_decode(i_paddr, 6'(NUM_CH));

  // one wait state lets the registered buffer read settle
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h00000000;
    end else begin
      pready_reg  <= apb_first;
      pslverr_reg <= apb_first && (sel == ACF_R_NONE);
      if (apb_first) begin
        prdata_reg <= prdata_next;
      end
    end
  end

  assign flt_ctl_view = {filter_enable_reg, filter_mode_reg,
                         filter_ratio_reg, filter_interrupt_enable_reg,
                         flt_rdy_reg, 3'h0,
                         filter_input_channel_reg}; // R7

  always_comb begin
    prdata_next = 32'h00000000;
    if (!i_pwrite) begin
      case (sel)
        ACF_R_CMP_CTL: prdata_next = {31'h00000000,
                                      below_low_event_enable_reg};
        ACF_R_LOW_THR: prdata_next = {16'h0000, low_threshold_reg};
        ACF_R_MASK_LO: prdata_next = {16'h0000,
                                      channel_compare_enable_reg[15:0]};
        ACF_R_MASK_HI: prdata_next = {30'h00000000,
                                      channel_compare_enable_reg[17:16]}; // R5
        ACF_R_FLT_CTL: prdata_next = {16'h0000, flt_ctl_view};
        ACF_R_FLT_DAT: prdata_next = flt_data_reg;
        ACF_R_IRQ_STS: prdata_next = {30'h00000000, irq_sts_reg};
        ACF_R_IRQ_MSK: prdata_next = {30'h00000000, irq_msk_reg};
        ACF_R_CMP_CHN: prdata_next = {27'h0000000, cmp_chan_reg};
        ACF_R_BUF:     prdata_next = {16'h0000, mem_bus.rd_data};
        default:       prdata_next = 32'h00000000;
      endcase
    end
  end

  // buffer read starts in the setup cycle, data ready in the access cycle
  assign mem_bus.rd_en   = apb_setup && !i_pwrite;
  assign mem_bus.rd_addr = i_paddr[6:2];

  // comparator and channel-mask registers
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      below_low_event_enable_reg <= `ACF_RST_CTL == 16'h0000 ? 1'b0 : 1'b1;
      low_threshold_reg          <= `ACF_RST_THR;
      channel_compare_enable_reg <= `ACF_RST_MASK; // R6
    end else if (apb_wr) begin
      case (sel)
        ACF_R_CMP_CTL: below_low_event_enable_reg <=
                         i_pwdata[`ACF_BIT_BLL];
        ACF_R_LOW_THR: low_threshold_reg <= i_pwdata[15:0];
        ACF_R_MASK_LO: channel_compare_enable_reg[15:0] <=
                         i_pwdata[15:0]; // R2
        ACF_R_MASK_HI: channel_compare_enable_reg[17:16] <=
                         i_pwdata[`ACF_MASK_HI_W-1:0]; // R4 R5
        default: ;
      endcase
    end
  end

  // result stage: buffer write and compare happen once per new result
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      res_vld_reg  <= 1'b0;
      res_chan_reg <= 5'h00;
      res_data_reg <= 16'h0000;
    end else begin
      res_vld_reg <= i_res_valid; // R9
      if (i_res_valid) begin
        res_chan_reg <= i_res_chan;
        res_data_reg <= i_res_data;
      end
    end
  end

  assign mem_bus.wr_en   = res_vld_reg;
  assign mem_bus.wr_addr = res_chan_reg;
  assign mem_bus.wr_data = res_data_reg;

  // out-of-range channel codes never index the mask
  assign chan_en = (32'(res_chan_reg) < NUM_CH) &&
                   channel_compare_enable_reg[res_chan_reg]; // R2 R3 R4
  assign cmp_hit = res_vld_reg && chan_en && below_low_event_enable_reg &&
                   (res_data_reg < low_threshold_reg); // R1

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      cmp_event_reg <= 1'b0;
      cmp_chan_reg  <= 5'h00;
    end else begin
      cmp_event_reg <= cmp_hit; // R1 R9
      if (cmp_hit) begin
        cmp_chan_reg <= res_chan_reg;
      end
    end
  end

  // filter control register; ready is hardware-owned
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      filter_enable_reg           <= 1'b0;
      filter_mode_reg             <= 2'h0;
      filter_ratio_reg            <= 3'h0;
      filter_interrupt_enable_reg <= 1'b0;
      filter_input_channel_reg    <= 5'h00;
    end else if (apb_wr && sel == ACF_R_FLT_CTL) begin
      filter_enable_reg           <= i_pwdata[`ACF_BIT_FLT_EN]; // R7
      filter_mode_reg             <= i_pwdata[`ACF_LSB_FLT_MODE +: 2];
      filter_ratio_reg            <= i_pwdata[`ACF_LSB_FLT_RAT +: 3];
      filter_interrupt_enable_reg <= i_pwdata[`ACF_BIT_FLT_IE];
      filter_input_channel_reg    <= i_pwdata[`ACF_LSB_FLT_CHN +: 5];
    end
  end

  // codes 16 and 17 are the temperature and band-gap result slots;
  // reserved codes never match a result, so nothing accumulates
  assign flt_take    = res_vld_reg && filter_enable_reg &&
                       (32'(filter_input_channel_reg) < NUM_CH) &&
                       (res_chan_reg == filter_input_channel_reg); // R8
  assign flt_cnt_inc = 9'(flt_cnt_reg + 9'h001);
  assign flt_target  = 9'(9'h002 << filter_ratio_reg);
  assign flt_sum_inc = 25'(flt_sum_reg + {9'h000, res_data_reg});
  assign flt_done    = flt_take && (flt_cnt_inc == flt_target);

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      flt_sum_reg  <= 25'h0000000;
      flt_cnt_reg  <= 9'h000;
      flt_data_reg <= 32'h00000000;
    end else if (!filter_enable_reg) begin
      flt_sum_reg <= 25'h0000000;
      flt_cnt_reg <= 9'h000;
    end else if (flt_done) begin
      flt_sum_reg  <= 25'h0000000;
      flt_cnt_reg  <= 9'h000;
      flt_data_reg <= {7'h00, flt_sum_inc};
    end else if (flt_take) begin
      flt_sum_reg <= flt_sum_inc;
      flt_cnt_reg <= flt_cnt_inc;
    end
  end

  // a completed filter sum (flt_done) beats the read that would clear ready
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      flt_rdy_reg <= 1'b0;
    end else if (!filter_enable_reg) begin
      flt_rdy_reg <= 1'b0; // R7
    end else if (flt_done) begin
      flt_rdy_reg <= 1'b1;
    end else if (apb_rd && sel == ACF_R_FLT_DAT) begin
      flt_rdy_reg <= 1'b0;
    end
  end

  // sticky status, write one to clear, set wins
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_sts_reg <= `ACF_RST_IRQ;
      irq_msk_reg <= `ACF_RST_IRQ;
      irq_reg     <= 1'b0;
    end else begin
      if (apb_wr && sel == ACF_R_IRQ_MSK) begin
        irq_msk_reg <= i_pwdata[1:0];
      end
      irq_sts_reg[`ACF_BIT_IRQ_CMP] <= cmp_hit ||
        (irq_sts_reg[`ACF_BIT_IRQ_CMP] &&
         !(apb_wr && sel == ACF_R_IRQ_STS && i_pwdata[`ACF_BIT_IRQ_CMP]));
      irq_sts_reg[`ACF_BIT_IRQ_FLT] <=
        (flt_done && filter_interrupt_enable_reg) ||
        (irq_sts_reg[`ACF_BIT_IRQ_FLT] &&
         !(apb_wr && sel == ACF_R_IRQ_STS && i_pwdata[`ACF_BIT_IRQ_FLT]));
      irq_reg <= |(irq_sts_reg & irq_msk_reg);
    end
  end

  acf_result_mem #(.DEPTH(NUM_CH)) u_mem (
    .i_clk_sys (i_clk_sys),
    .i_resetn  (i_resetn),
    .port      (mem_bus.mem)
  );

  assign o_prdata    = prdata_reg;
  assign o_pready    = pready_reg;
  assign o_pslverr   = pslverr_reg;
  assign o_cmp_event = cmp_event_reg;
  assign o_cmp_chan  = cmp_chan_reg;
  assign o_flt_ready = flt_rdy_reg;
  assign o_irq       = irq_reg;

  logic hit_en_d;
  assign hit_en_d = chan_en;

  a_low_event_fires: assert property ( // R1
    (i_res_valid && below_low_event_enable_reg) ##1
    (cmp_hit) |=> o_cmp_event && o_cmp_chan == $past(res_chan_reg))
    else $error("low-threshold hit gave no event");

  a_low_needs_enable: assert property ( // R1
    o_cmp_event |-> $past(below_low_event_enable_reg))
    else $error("event while below-low enable was clear");

  a_masked_channel: assert property ( // R3
    o_cmp_event |-> $past(hit_en_d))
    else $error("event from a disabled channel");

  a_mask_low_write: assert property ( // R2
    (apb_wr && sel == ACF_R_MASK_LO) |=>
    channel_compare_enable_reg[15:0] == $past(i_pwdata[15:0]))
    else $error("low mask write not stored");

  a_mask_high_write: assert property ( // R4
    (apb_wr && sel == ACF_R_MASK_HI) |=>
    channel_compare_enable_reg[17:16] == $past(i_pwdata[1:0]))
    else $error("high mask write not stored");

  a_mask_high_zero: assert property ( // R5
    (apb_done && !i_pwrite && sel == ACF_R_MASK_HI) |->
    o_prdata[31:2] == 30'h00000000)
    else $error("high mask upper bits not zero");

  a_filter_gap_zero: assert property ( // R7
    (apb_done && !i_pwrite && sel == ACF_R_FLT_CTL) |->
    o_prdata[7:5] == 3'h0 && o_prdata[8] == $past(flt_rdy_reg))
    else $error("filter control read layout wrong");

  a_ready_off_idle: assert property ( // R7
    !filter_enable_reg |=> !flt_rdy_reg)
    else $error("ready set while filter disabled");

  // disabling clears the count, so only an enabled filter must hold it
  a_reserved_code: assert property ( // R8
    (filter_enable_reg && 32'(filter_input_channel_reg) >= NUM_CH) |=>
    $stable(flt_cnt_reg))
    else $error("reserved filter channel accumulated");

  a_compare_latency: assert property ( // R9
    $rose(o_cmp_event) |-> $past(i_res_valid, 2))
    else $error("event not two cycles after its result");

endmodule

/* tb/acf_adc_cmp_filter_tb.sv */
// Purpose: self-checking bench of the adc compare/filter block
// Assumes: apb slave answers with pready; results are one-cycle strobes
// Notes:   random values from a fixed seed, boundary values mixed in
`timescale 1ns/10ps

`include "acf_cfg.svh"

module acf_adc_cmp_filter_tb import acf_pkg::*;;
  logic        i_clk_sys;
  logic        i_resetn;
  logic        i_psel;
  logic        i_penable;
  logic        i_pwrite;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata;
  logic [31:0] o_prdata;
  logic        o_pready;
  logic        o_pslverr;
  logic        i_res_valid;
  acf_chan_t   i_res_chan;
  acf_sample_t i_res_data;
  logic        o_cmp_event;
  acf_chan_t   o_cmp_chan;
  logic        o_flt_ready;
  logic        o_irq;
  int          err_total;
  int          checks;

  acf_adc_cmp_filter #(.NUM_CH(18)) dut_u (
    .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_res_valid(i_res_valid),
    .i_res_chan(i_res_chan), .i_res_data(i_res_data),
    .o_cmp_event(o_cmp_event), .o_cmp_chan(o_cmp_chan),
    .o_flt_ready(o_flt_ready), .o_irq(o_irq));

  always #2.5 i_clk_sys = ~i_clk_sys;

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk_word(input string what, input logic [31:0] exp_v,
                          input logic [31:0] got_v);
    checks++;
    if (got_v !== exp_v) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp_v, got_v);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp_v,
                         input logic got_v);
    checks++;
    if (got_v !== exp_v) begin
      err_total++;
      $display("unexpected %s: expected %b, seen %b", what, exp_v, got_v);
    end
  endtask

  // request held from setup until pready is sampled high
  task automatic apb(input logic is_wr, input logic [11:0] addr,
                     input logic [31:0] wdata, output logic [31:0] rdata,
                     output logic err);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    i_psel    <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite  <= is_wr;
    i_paddr   <= addr;
    i_pwdata  <= wdata;
    @(posedge i_clk_sys);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
      wrap_up();
    end
    rdata = o_prdata;
    err = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] addr, input logic [31:0] v);
    logic [31:0] d;
    logic        e;
    apb(1'b1, addr, v, d, e);
    chk_bit("write error flag", 1'b0, e);
  endtask

  task automatic rd_chk(input string what, input logic [11:0] addr,
                        input logic [31:0] exp_v);
    logic [31:0] d;
    logic        e;
    apb(1'b0, addr, 32'h0, d, e);
    chk_word(what, exp_v, d);
  endtask

  task automatic send(input logic [4:0] ch, input logic [15:0] v);
    @(posedge i_clk_sys);
    i_res_valid <= 1'b1;
    i_res_chan  <= ch;
    i_res_data  <= v;
    @(posedge i_clk_sys);
    i_res_valid <= 1'b0;
  endtask

  function automatic logic exp_evt(input logic bll, input logic [17:0] m,
                                   input logic [15:0] thr,
                                   input logic [4:0] ch,
                                   input logic [15:0] v);
    if (ch >= 5'd18) begin
      return 1'b0;
    end
    return bll & m[ch] & (v < thr);
  endfunction

  // back-to-back results, event checked two cycles after each strobe
  task automatic run_cmp(input logic bll, input logic [17:0] m,
                         input logic [15:0] thr, output logic any);
    logic       e[0:21];
    logic [4:0] c[0:21];
    logic [4:0] ch;
    logic [15:0] v;
    logic [4:0] lst;
    any = 1'b0;
    lst = 5'h00;
    wr(`ACF_OFF_CMP_CTL, {31'h0, bll});
    wr(`ACF_OFF_LOW_THR, {16'h0, thr});
    wr(`ACF_OFF_MASK_LO, {16'h0, m[15:0]});
    wr(`ACF_OFF_MASK_HI, {30'h0, m[17:16]});
    for (int i = 0; i < 24; i++) begin
      @(posedge i_clk_sys);
      if (i < 22) begin
        ch = (i < 20) ? 5'(i) : 5'($urandom_range(17, 0));
        v = (i == 3) ? thr : (i == 4) ? thr - 16'h1 : 16'($urandom);
        i_res_valid <= 1'b1;
        i_res_chan  <= ch;
        i_res_data  <= v;
        e[i] = exp_evt(bll, m, thr, ch, v);
        c[i] = ch;
        any = any | e[i];
        if (e[i]) begin
          lst = ch;
        end
      end else begin
        i_res_valid <= 1'b0;
      end
      if (i >= 2) begin
        #1;
        chk_bit("compare event", e[i-2], o_cmp_event);
        if (e[i-2]) begin
          chk_word("event channel", {27'h0, c[i-2]},
                   {27'h0, o_cmp_chan});
        end
      end
    end
    if (any) begin
      rd_chk("last event channel", `ACF_OFF_CMP_CHN, {27'h0, lst});
    end
  endtask

  initial begin
    repeat (50000) @(posedge i_clk_sys);
    err_total++;
    wrap_up();
  end

  initial begin
    logic [11:0] offs[4];
    logic [31:0] d;
    logic        e;
    logic        any;
    logic [15:0] thr;
    logic [15:0] s0;
    logic [15:0] s1;
    int          n;
    offs = '{`ACF_OFF_CMP_CTL, `ACF_OFF_MASK_LO, `ACF_OFF_MASK_HI,
             `ACF_OFF_FLT_CTL};
    i_clk_sys = 1'b0;
    i_resetn = 1'b0;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 12'h000;
    i_pwdata = 32'h0;
    i_res_valid = 1'b0;
    i_res_chan = 5'h00;
    i_res_data = 16'h0000;
    err_total = 0;
    checks = 0;
    void'($urandom(32'h7daac1a9));
    repeat (8) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    foreach (offs[k]) rd_chk("reset value", offs[k], 32'h0);
    wr(`ACF_OFF_MASK_HI, 32'hffffffff);
    rd_chk("mask high", `ACF_OFF_MASK_HI, 32'h3);
    wr(`ACF_OFF_MASK_LO, 32'hffffffff);
    rd_chk("mask low", `ACF_OFF_MASK_LO, 32'hffff);
    d = $urandom;
    wr(`ACF_OFF_FLT_CTL, d);
    rd_chk("filter control", `ACF_OFF_FLT_CTL, d & 32'hfe1f);
    wr(`ACF_OFF_FLT_CTL, 32'h0);
    apb(1'b0, 12'h024, 32'h0, d, e);
    chk_bit("unmapped error", 1'b1, e);
    chk_word("unmapped data", 32'h0, d);
    apb(1'b1, 12'h002, 32'h1, d, e);
    chk_bit("misaligned error", 1'b1, e);
    // three passes: random mask, all channels, enable off
    for (int r = 0; r < 3; r++) begin
      wr(`ACF_OFF_IRQ_MSK, (r == 1) ? 32'h0 : 32'h1);
      thr = 16'($urandom_range(16'hffff, 1));
      run_cmp(r != 2, (r == 0) ? 18'($urandom) : 18'h3ffff, thr, any);
      rd_chk("low threshold", `ACF_OFF_LOW_THR, {16'h0, thr});
      repeat (2) @(posedge i_clk_sys);
      #1;
      chk_bit("compare irq", any & (r != 1), o_irq);
      rd_chk("irq status", `ACF_OFF_IRQ_STS, {31'h0, any});
      wr(`ACF_OFF_IRQ_STS, 32'h3);
      repeat (2) @(posedge i_clk_sys);
      #1;
      chk_bit("irq after clear", 1'b0, o_irq);
    end
    wr(`ACF_OFF_IRQ_MSK, 32'h3);
    // temperature and band-gap codes, foreign channel in between
    for (int k = 16; k < 18; k++) begin
      wr(`ACF_OFF_FLT_CTL, 32'h8200 | k);
      s0 = 16'($urandom);
      s1 = 16'($urandom);
      send(5'(k), s0);
      send(5'h0f, 16'($urandom));
      send(5'(k), s1);
      n = 0;
      do begin
        @(posedge i_clk_sys);
        #1;
        n++;
      end while (o_flt_ready !== 1'b1 && n < 10);
      if (o_flt_ready !== 1'b1) begin
        err_total++;
        wrap_up();
      end
      chk_word("filter latency", 32'd1, 32'(n));
      chk_bit("filter ready", 1'b1, o_flt_ready);
      // the interrupt line trails the status bit by one clock
      @(posedge i_clk_sys);
      #1;
      chk_bit("filter irq", 1'b1, o_irq);
      rd_chk("filter control", `ACF_OFF_FLT_CTL, 32'h8300 | k);
      rd_chk("filter data", `ACF_OFF_FLT_DAT, s0 + s1);
      rd_chk("result buffer", 12'(12'h080 + 4 * k), {16'h0, s1});
      repeat (2) @(posedge i_clk_sys);
      #1;
      chk_bit("ready after read", 1'b0, o_flt_ready);
      rd_chk("irq status", `ACF_OFF_IRQ_STS, 32'h2);
      wr(`ACF_OFF_IRQ_STS, 32'h3);
      wr(`ACF_OFF_FLT_CTL, 32'h0);
    end
    // reserved select code: matching results must never accumulate
    wr(`ACF_OFF_FLT_CTL, 32'h8212);
    send(5'h12, 16'($urandom));
    send(5'h12, 16'($urandom));
    repeat (3) @(posedge i_clk_sys);
    #1;
    chk_bit("reserved ready", 1'b0, o_flt_ready);
    rd_chk("reserved status", `ACF_OFF_IRQ_STS, 32'h0);
    wr(`ACF_OFF_FLT_CTL, 32'h0);
    wrap_up();
  end
endmodule
